// ### rtl/pmc_array.v
// output macrocell array top: ten cells, apb configuration and status
//
// How it works
// - ten cells in five pairs taking 8,10,12,14,16 logic terms
// - each cell has its own extra term that only drives output enable
// - every cell picks true or inverted pin polarity in either mode
// - the shared clear term zeroes every register at once, unclocked
// - the shared set term loads ones on the next rising clock edge
// - one clear term and one set term serve every registered cell
// - clear and set act on the flop, pin level then follows polarity
// - two bits per cell choose registered or combinatorial and polarity
// - registered cells drive the pin from the flop through the buffer
// - registered cells feed the inverted flop output back, both senses
// - registered cells gate their output with their own enable term
// - registered pins are output only, pin values never reach the array
// - combinatorial cells drive the pin straight from the sum gate
// - combinatorial enable is always on, always off or term driven
// - combinatorial feedback comes from the pin, true and inverted
`timescale 1ns/100ps
`include "pmc_defines.vh"

module pmc_array (
    input  wire                         clock,
    input  wire                         rst,
    // apb slave
    input  wire                         psel,
    input  wire                         penable,
    input  wire                         pwrite,
    input  wire [`PMC_ADDR_W-1:0]       paddr,
    input  wire [31:0]                  pwdata,
    output reg  [31:0]                  prdata,
    output reg                          pready,
    output reg                          pslverr,
    // product terms from the and array
    input  wire [`PMC_TOTAL_TERMS-1:0]  logic_terms,
    input  wire [`PMC_NUM_CELLS-1:0]    oe_terms,
    input  wire                         async_clear_term,
    input  wire                         sync_set_term,
    // pins and feedback
    input  wire [`PMC_NUM_CELLS-1:0]    pin_in,
    output reg  [`PMC_NUM_CELLS-1:0]    pin_out,
    output reg  [`PMC_NUM_CELLS-1:0]    pin_oe,
    output reg  [`PMC_NUM_CELLS-1:0]    fb_true,
    output reg  [`PMC_NUM_CELLS-1:0]    fb_comp
);

    // ----------------------------------------------------------------
    // configuration and event registers
    // ----------------------------------------------------------------
    reg  [`PMC_NUM_CELLS-1:0]   pol_reg;           // 1 = true polarity
    reg  [`PMC_NUM_CELLS-1:0]   mode_reg;          // mode_select_bit1, 1 = combinatorial
    reg  [2*`PMC_NUM_CELLS-1:0] oecfg_reg;
    reg                         clr_seen_reg;
    reg                         set_seen_reg;
    reg                         clr_seen_next;
    reg                         set_seen_next;

    // ----------------------------------------------------------------
    // per-cell signals
    // ----------------------------------------------------------------
    wire [`PMC_NUM_CELLS-1:0]   cell_level;
    wire [`PMC_NUM_CELLS-1:0]   cell_enable;
    wire [`PMC_NUM_CELLS-1:0]   cell_fb_true;
    wire [`PMC_NUM_CELLS-1:0]   cell_fb_comp;
    wire [`PMC_NUM_CELLS-1:0]   cell_q;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable & pready;
    wire wr_access    = access_phase & pwrite;
    wire hit_cfg      = (paddr == `PMC_CFG_OFF);
    wire hit_oecfg    = (paddr == `PMC_OECFG_OFF);
    wire hit_stat     = (paddr == `PMC_STAT_OFF);
    wire hit_evt      = (paddr == `PMC_EVT_OFF);
    wire hit_any      = hit_cfg | hit_oecfg | hit_stat | hit_evt;

    // ----------------------------------------------------------------
    // macrocell instances
    // ----------------------------------------------------------------
    // term slice of cell i: pairs grow by two terms, earlier pairs first
    genvar i;
    generate
        for (i = 0; i < `PMC_NUM_CELLS; i = i + 1) begin : g_cell
            localparam PAIR  = i / 2;
            localparam NT    = `PMC_BASE_TERMS + `PMC_TERM_STEP * PAIR;
            localparam OFF   = 2 * (`PMC_BASE_TERMS * PAIR + PAIR * (PAIR - 1)) + (i % 2) * NT;

            // one clear and one set term fan out to every cell
            pmc_macrocell #(
                .NTERMS (NT)
            ) u_cell (
                .clock            (clock),
                .rst              (rst),
                .logic_terms      (logic_terms[OFF +: NT]),
                .oe_term          (oe_terms[i]),
                .async_clear_term (async_clear_term),
                .sync_set_term    (sync_set_term),
                .mode_select_bit1 (mode_reg[i]),
                .polarity_true    (pol_reg[i]),
                .oe_select        (oecfg_reg[2*i +: 2]),
                .pin_in           (pin_in[i]),
                .pin_level        (cell_level[i]),
                .pin_enable       (cell_enable[i]),
                .fb_true          (cell_fb_true[i]),
                .fb_comp          (cell_fb_comp[i]),
                .q                (cell_q[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin and feedback output stage
    // ----------------------------------------------------------------
    // outputs are retimed by one clock so every top port is a flop;
    // this costs a cycle of latency on the combinatorial path
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_out <= {`PMC_NUM_CELLS{1'b0}};
            pin_oe  <= {`PMC_NUM_CELLS{1'b0}};
            fb_true <= {`PMC_NUM_CELLS{1'b0}};
            fb_comp <= {`PMC_NUM_CELLS{1'b0}};
        end else begin
            pin_out <= cell_level;
            pin_oe  <= cell_enable;
            fb_true <= cell_fb_true;
            fb_comp <= cell_fb_comp;
        end
    end

    // ----------------------------------------------------------------
    // configuration writes
    // ----------------------------------------------------------------
    // changing mode on the fly is allowed; the flop keeps its value
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pol_reg   <= `PMC_POL_RST;
            mode_reg  <= `PMC_MODE_RST;
            oecfg_reg <= `PMC_OECFG_RST;
        end else if (wr_access) begin
            if (hit_cfg) begin
                pol_reg  <= pwdata[`PMC_CFG_POL_LSB +: `PMC_NUM_CELLS];
                mode_reg <= pwdata[`PMC_CFG_MODE_LSB +: `PMC_NUM_CELLS];
            end
            if (hit_oecfg) begin
                oecfg_reg <= pwdata[2*`PMC_NUM_CELLS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky event flags for clear and set terms
    // ----------------------------------------------------------------
    // write one to clear; a term seen in the same cycle wins over it
    always @* begin
        clr_seen_next = clr_seen_reg;
        set_seen_next = set_seen_reg;
        if (wr_access && hit_evt && pwdata[`PMC_EVT_CLR_BIT]) begin
            clr_seen_next = 1'b0;
        end
        if (wr_access && hit_evt && pwdata[`PMC_EVT_SET_BIT]) begin
            set_seen_next = 1'b0;
        end
        if (async_clear_term) begin
            clr_seen_next = 1'b1;
        end
        if (sync_set_term) begin
            set_seen_next = 1'b1;
        end
    end

    // flags hold until software clears them
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            clr_seen_reg <= 1'b0;
            set_seen_reg <= 1'b0;
        end else begin
            clr_seen_reg <= clr_seen_next;
            set_seen_reg <= set_seen_next;
        end
    end

    // ----------------------------------------------------------------
    // apb response
    // ----------------------------------------------------------------
    // ready comes up in the access cycle, so every transfer has no wait;
    // read data is captured in setup and held through access
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= ~hit_any;
            prdata  <= 32'h00000000;
            if (!pwrite) begin
                if (hit_cfg) begin
                    prdata[`PMC_CFG_POL_LSB +: `PMC_NUM_CELLS]  <= pol_reg;
                    prdata[`PMC_CFG_MODE_LSB +: `PMC_NUM_CELLS] <= mode_reg;
                end
                if (hit_oecfg) begin
                    prdata[2*`PMC_NUM_CELLS-1:0] <= oecfg_reg;
                end
                if (hit_stat) begin
                    prdata[`PMC_STAT_Q_LSB +: `PMC_NUM_CELLS]   <= cell_q;
                    prdata[`PMC_STAT_PIN_LSB +: `PMC_NUM_CELLS] <= pin_out;
                end
                if (hit_evt) begin
                    prdata[`PMC_EVT_CLR_BIT] <= clr_seen_reg;
                    prdata[`PMC_EVT_SET_BIT] <= set_seen_reg;
                end
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // pmc_array

// ### rtl/pmc_defines.vh
// constants for the output macrocell array: offsets, fields, reset values
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ----------------------------------------------------------------
// array shape
// ----------------------------------------------------------------
`define PMC_NUM_CELLS      10
`define PMC_NUM_PAIRS      5
`define PMC_BASE_TERMS     8
`define PMC_TERM_STEP      2
`define PMC_MAX_TERMS      16
`define PMC_TOTAL_TERMS    120

// ----------------------------------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMC_ADDR_W         12
`define PMC_CFG_OFF        12'h000
`define PMC_OECFG_OFF      12'h004
`define PMC_STAT_OFF       12'h008
`define PMC_EVT_OFF        12'h00C

// ----------------------------------------------------------------
// configuration, status and event register fields
// ----------------------------------------------------------------
`define PMC_CFG_POL_LSB    0
`define PMC_CFG_MODE_LSB   16
`define PMC_STAT_Q_LSB     0
`define PMC_STAT_PIN_LSB   16
`define PMC_EVT_CLR_BIT    0
`define PMC_EVT_SET_BIT    1

// ----------------------------------------------------------------
// output enable select codes for combinatorial cells
// ----------------------------------------------------------------
`define PMC_OE_OFF         2'h0
`define PMC_OE_ON          2'h1
`define PMC_OE_TERM        2'h2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMC_POL_RST        10'h3FF
`define PMC_MODE_RST       10'h000
`define PMC_OECFG_RST      20'h00000

`endif

// ### rtl/pmc_macrocell.v
// one output macrocell: sum gate, d flip-flop, polarity, enable and feedback
`timescale 1ns/100ps
`include "pmc_defines.vh"

module pmc_macrocell #(
    parameter NTERMS = 8
) (
    input  wire              clock,
    input  wire              rst,
    input  wire [NTERMS-1:0] logic_terms,
    input  wire              oe_term,
    input  wire              async_clear_term,
    input  wire              sync_set_term,
    input  wire              mode_select_bit1,
    input  wire              polarity_true,
    input  wire [1:0]        oe_select,
    input  wire              pin_in,
    output wire              pin_level,
    output reg               pin_enable,
    output wire              fb_true,
    output wire              fb_comp,
    output wire              q
);

    // ----------------------------------------------------------------
    // sum term and register
    // ----------------------------------------------------------------
    wire sum_term  = |logic_terms;
    wire clear_any = rst | async_clear_term;
    reg  q_reg;

    // clear is level sensitive through the async pin, no clock needed
    always @(posedge clock or posedge clear_any) begin
        if (clear_any) begin
            q_reg <= 1'b0;
        end else if (sync_set_term) begin
            q_reg <= 1'b1;
        end else begin
            q_reg <= sum_term;
        end
    end
    assign q = q_reg;

    // ----------------------------------------------------------------
    // output path
    // ----------------------------------------------------------------
    // polarity applied after the flop, so clear/set stay on q itself
    wire out_src = mode_select_bit1 ? sum_term : q_reg;
    assign pin_level = polarity_true ? out_src : ~out_src;

    // enable: registered cells always follow their own term
    always @* begin
        if (!mode_select_bit1) begin
            pin_enable = oe_term;
        end else begin
            case (oe_select)
                `PMC_OE_ON:   pin_enable = 1'b1;
                `PMC_OE_TERM: pin_enable = oe_term;
                default:      pin_enable = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // feedback into the and array
    // ----------------------------------------------------------------
    // registered cells never look at the pin, so it is output only
    assign fb_comp = mode_select_bit1 ? ~pin_in : ~q_reg;
    assign fb_true = ~fb_comp;

endmodule // pmc_macrocell

// ### testbench/pmc_array_checker.sv
// checker: timing and mode relations at the macrocell array ports
`timescale 1ns/100ps
`include "pmc_defines.vh"

module pmc_array_checker (
    input wire        clock,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire [9:0]  oe_terms,
    input wire        async_clear_term,
    input wire        sync_set_term,
    input wire [9:0]  pin_in,
    input wire [9:0]  pin_out,
    input wire [9:0]  pin_oe,
    input wire [9:0]  fb_true,
    input wire [9:0]  fb_comp
);
    // ----------------
    // config mirror
    // ----------------
    reg [9:0] pol_reg;
    reg [9:0] mode_reg;

    // follows completed config writes, so no peeking inside the design
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pol_reg  <= `PMC_POL_RST;
            mode_reg <= `PMC_MODE_RST;
        end else if (psel && penable && pready && pwrite && paddr == `PMC_CFG_OFF) begin
            pol_reg  <= pwdata[9:0];
            mode_reg <= pwdata[25:16];
        end
    end

    // ----------------
    // assertions
    // ----------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    AST_NO_WAIT: assert property (psel && !penable |=> pready)
        else $error("access cycle without pready");
    AST_UNMAPPED: assert property (pready |-> pslverr == (paddr != `PMC_CFG_OFF && paddr != `PMC_OECFG_OFF &&
        paddr != `PMC_STAT_OFF && paddr != `PMC_EVT_OFF))
        else $error("pslverr does not match the address map");
    AST_FB_BOTH: assert property (!$past(rst) |-> fb_comp == ~fb_true)
        else $error("feedback pair not complementary");
    AST_REG_PIN: assert property (((pin_out ^ fb_true ^ ~$past(pol_reg)) & ~$past(mode_reg)) == 10'h000)
        else $error("registered pin does not follow flop and polarity");
    AST_CLEAR: assert property (async_clear_term |=>
        ((fb_true | (pin_out ^ ~$past(pol_reg))) & ~$past(mode_reg)) == 10'h000)
        else $error("clear term did not zero the registers");
    AST_SET: assert property (sync_set_term && !async_clear_term ##1 !async_clear_term |=>
        (~fb_true & ~$past(mode_reg)) == 10'h000)
        else $error("set term did not load ones");
    AST_REG_OE: assert property (1'b1 |=> ((pin_oe ^ $past(oe_terms)) & ~$past(mode_reg)) == 10'h000)
        else $error("registered enable not from its own term");
    AST_COMB_FB: assert property (1'b1 |=> ((fb_true ^ $past(pin_in)) & $past(mode_reg)) == 10'h000)
        else $error("combinatorial feedback not from the pin");
endmodule // pmc_array_checker

bind pmc_array pmc_array_checker u_chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .oe_terms(oe_terms), .async_clear_term(async_clear_term), .sync_set_term(sync_set_term),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .fb_true(fb_true), .fb_comp(fb_comp));

// ### testbench/pmc_board_model.sv
// board model: resolves the ten i/o pin levels seen by the array
`timescale 1ns/100ps

module pmc_board_model (
    input  wire [9:0] pin_out,
    input  wire [9:0] pin_oe,
    input  wire [9:0] ext_val,
    input  wire [9:0] ext_en,
    output wire [9:0] pin_in
);
    // device wins where both drive; an undriven pin floats to its pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // pmc_board_model

// ### testbench/test_pmc_array.sv
// self-checking bench for the output macrocell array
`timescale 1ns/100ps
`include "pmc_defines.vh"

module test_pmc_array;
    reg          clock            = 1'b0;
    reg          rst              = 1'b1;
    reg          psel             = 1'b0;
    reg          penable          = 1'b0;
    reg          pwrite           = 1'b0;
    reg  [11:0]  paddr            = 12'h000;
    reg  [31:0]  pwdata           = 32'h00000000;
    reg  [119:0] logic_terms      = 120'h0;
    reg  [9:0]   oe_terms         = 10'h000;
    reg          async_clear_term = 1'b0;
    reg          sync_set_term    = 1'b0;
    reg  [9:0]   ext_val          = 10'h000;
    reg  [9:0]   ext_en           = 10'h000;
    wire [31:0]  prdata;
    wire         pready;
    wire         pslverr;
    wire [9:0]   pin_in;
    wire [9:0]   pin_out;
    wire [9:0]   pin_oe;
    wire [9:0]   fb_true;
    wire [9:0]   fb_comp;
    reg  [31:0]  rd;
    reg  [31:0]  r;
    reg          err;
    reg  [9:0]   pol;
    reg  [9:0]   sum;
    reg  [9:0]   oe;
    reg  [9:0]   pin;
    reg  [19:0]  oecfg;
    integer      failures = 0;
    integer      checks   = 0;
    integer      cycles   = 0;
    integer      n;
    integer      c;

    pmc_array dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .logic_terms(logic_terms), .oe_terms(oe_terms), .async_clear_term(async_clear_term),
        .sync_set_term(sync_set_term), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .fb_true(fb_true), .fb_comp(fb_comp));
    pmc_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(pin_in));

    // ----------------
    // clock, hang guard, helpers
    // ----------------
    always #25 clock = ~clock;

    // the run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            wrap_up;
        end
    end

    // sum term of every cell: pairs take 8, 10, 12, 14, 16 terms in turn
    function [9:0] sums(input [119:0] t);
        integer k, b, off;
        begin
            off = 0;
            for (k = 0; k < 10; k = k + 1) begin
                sums[k] = 1'b0;
                for (b = 0; b < 8 + 2 * (k / 2); b = b + 1) sums[k] = sums[k] | t[off + b];
                off = off + 8 + 2 * (k / 2);
            end
        end
    endfunction

    // sparse terms so that sums come out both ways
    function [119:0] rnd_terms();
        reg [127:0] a;
        integer     w;
        begin
            for (w = 0; w < 4; w = w + 1) a[32 * w +: 32] = $urandom & $urandom & $urandom;
            rnd_terms = a[119:0];
        end
    endfunction

    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // one apb transfer, then an idle cycle so strobes never double up
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            psel   <= 1'b1;
            pwrite <= wr;
            paddr  <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            do @(posedge clock); while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clock);
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        n = $urandom(9499);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, `PMC_CFG_OFF, 32'h00000000);
        check("cfg", rd, 32'h000003FF);
        apb(1'b0, `PMC_OECFG_OFF, 32'h00000000);
        check("oecfg", rd, 32'h00000000);
        apb(1'b0, 12'h010, 32'h00000000);
        check("unmapped err", err, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        $display("test reset values done");
        // registered cells, random polarity, pins driven from outside
        for (n = 0; n < 24; n = n + 1) begin
            r = $urandom;
            pol = r[9:0];
            apb(1'b1, `PMC_CFG_OFF, {22'h000000, pol});
            r = $urandom;
            logic_terms <= (n == 0) ? 120'h0 : (n == 1) ? ~120'h0 : rnd_terms();
            oe_terms <= r[9:0];
            ext_en <= r[19:10];
            ext_val <= r[29:20];
            repeat (3) @(posedge clock);
            sum = sums(logic_terms);
            pin = ~(sum ^ pol);
            check("reg pin", pin_out, pin);
            check("reg fb", fb_true, sum);
            check("reg oe", pin_oe, oe_terms);
        end
        $display("test registered done");
        // combinatorial cells with every enable code
        for (n = 0; n < 24; n = n + 1) begin
            r = $urandom;
            pol = r[9:0];
            oecfg = r[31:12];
            apb(1'b1, `PMC_CFG_OFF, {6'h00, 10'h3FF, 6'h00, pol});
            apb(1'b1, `PMC_OECFG_OFF, {12'h000, oecfg});
            r = $urandom;
            logic_terms <= rnd_terms();
            oe_terms <= r[9:0];
            ext_en <= r[19:10];
            ext_val <= r[29:20];
            repeat (4) @(posedge clock);
            sum = sums(logic_terms);
            for (c = 0; c < 10; c = c + 1)
                oe[c] = oecfg[2*c +: 2] == `PMC_OE_ON || (oecfg[2*c +: 2] == `PMC_OE_TERM && oe_terms[c]);
            pin = ~(sum ^ pol);
            check("comb pin", pin_out, pin);
            check("comb oe", pin_oe, oe);
            pin = (oe & pin) | (~oe & ext_en & ext_val) | (~oe & ~ext_en);
            check("comb fb", fb_true, pin);
        end
        $display("test combinatorial done");
        // shared clear then set; the wait is two edges, one short of what a clocked clear would need to pass these checks
        r = $urandom;
        pol = r[9:0];
        apb(1'b1, `PMC_CFG_OFF, {22'h000000, pol});
        logic_terms <= ~120'h0;
        repeat (3) @(posedge clock);
        async_clear_term <= 1'b1;
        repeat (2) @(posedge clock);
        pin = ~pol;
        check("clear pin", pin_out, pin);
        check("clear fb", fb_true, 10'h000);
        sync_set_term <= 1'b1;
        apb(1'b0, `PMC_STAT_OFF, 32'h00000000);
        check("clear q", rd[9:0], 10'h000);
        check("clear stat pin", rd[25:16], pin);
        check("clear wins", pin_out, pin);
        async_clear_term <= 1'b0;
        logic_terms <= 120'h0;
        repeat (3) @(posedge clock);
        check("set pin", pin_out, pol);
        // set still held, so every flop must read back as one
        apb(1'b0, `PMC_STAT_OFF, 32'h00000000);
        check("set q", rd[9:0], 10'h3FF);
        check("set stat pin", rd[25:16], pol);
        sync_set_term <= 1'b0;
        repeat (3) @(posedge clock);
        check("after set", pin_out, pin);
        apb(1'b0, `PMC_EVT_OFF, 32'h00000000);
        check("events", rd, 32'h00000003);
        apb(1'b1, `PMC_EVT_OFF, 32'h00000003);
        apb(1'b0, `PMC_EVT_OFF, 32'h00000000);
        check("events cleared", rd, 32'h00000000);
        $display("test clear and set done");
        // second reset in mid-run: outputs drop at once, config returns
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        check("rst pin", pin_out, 10'h000);
        check("rst fb", fb_comp, 10'h000);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, `PMC_CFG_OFF, 32'h00000000);
        check("rst cfg", rd, 32'h000003FF);
        apb(1'b0, `PMC_EVT_OFF, 32'h00000000);
        check("rst events", rd, 32'h00000000);
        $display("test mid-run reset done");
        wrap_up;
    end
endmodule // test_pmc_array
